// ==== design/dfe_ecc_ctrl.sv ====
// formatter ecc control, sector extension and host lock registers
`timescale 1ns/1ps
`include "dfe_defines.svh"
module dfe_ecc_ctrl (
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata_ff,
    input  wire logic       disk_op_active,
    input  wire logic       disk_bit_valid,
    input  wire logic       disk_bit,
    input  wire logic       ecc_preset_ctrl,
    input  wire logic       inhibit_carry,
    input  wire logic       seq_underflow,
    output logic            underflow_pass_ff,
    input  wire logic       index_pin,
    input  wire logic       sector_pin,
    output logic            branch_cond_ff,
    output logic            fmt_reset_ff,
    output logic            gate_kill_ff,
    output logic            lines_drive_en_ff,
    output logic            ecc_busy_ff,
    output logic            corr_found_ff,
    input  wire logic       host_cmd,
    input  wire logic       host_auto_cmd,
    input  wire logic       host_stat_rd,
    output logic            bm_lock_ff,
    output logic            xfer_lock_ff,
    output logic            pwrdn_lock_ff,
    output logic            hrf_sel_lo_ff,
    output logic            hrf_sel_hi_ff
);
    logic [7:0]  sect_ff;
    logic [7:0]  ecc_ctl_ff;
    logic [7:0]  corr_ff;
    logic [7:0]  mode_ff;
    logic [8:0]  supp_cnt_ff;
    logic [2:0]  bit_cnt_ff;
    logic [8:0]  byte_cnt_ff;
    logic [2:0]  idx_sync_ff;
    logic [2:0]  sec_sync_ff;
    logic [55:0] syn;
    logic [55:0] load_val;
    logic [7:0]  syn_byte [4];
    logic [7:0]  nxt_ctl;
    logic [7:0]  rd_mux;
    logic        fmt_rst;
    logic        ctl_wr;
    logic        corr_wr;
    logic        found;
    logic        search_stop;
    logic        rev_done;
    logic        ecc_clr_now;
    logic        load_en;
    logic        shift_en;
    logic        din;
    logic        suppress;
    dfe_pkg::dfe_ecc_state_type state_ff;

    assign fmt_rst = ecc_ctl_ff[`DFE_ECC_FRST];
    assign ctl_wr  = reg_wr && reg_addr == `DFE_ADDR_ECC_CTL;
    assign corr_wr = reg_wr && reg_addr == `DFE_ADDR_CORR;

    // correctable: nonzero burst confined to the low byte of the length
    assign found = (ecc_ctl_ff[`DFE_ECC_LEN56] ? syn[55:8] == 48'h0
                                               : syn[31:8] == 24'h0)
                   && syn[7:0] != 8'h0;
    assign search_stop = state_ff == dfe_pkg::ECC_SEARCH
                         && bit_cnt_ff == 3'h0
                         && (found || byte_cnt_ff == `DFE_SEARCH_BYTES);
    assign rev_done = state_ff == dfe_pkg::ECC_REVERSE
                      && bit_cnt_ff == `DFE_LAST_BIT;
    // clearing waits while a disk operation runs
    assign ecc_clr_now = ecc_ctl_ff[`DFE_ECC_CLR] && !disk_op_active;

    // syndrome load: formatter reset preset, else a clear
    always_comb
    begin
        load_en  = fmt_rst || ecc_clr_now;
        load_val = 56'h0;
        if (fmt_rst && !ecc_preset_ctrl)
            load_val = {56{1'b1}};
    end

    // shift source: correction register, zeros in search, or disk bits
    always_comb
    begin
        shift_en = 1'b0;
        din      = 1'b0;
        case (state_ff)
            dfe_pkg::ECC_REVERSE:
            begin
                shift_en = 1'b1;
                din      = corr_ff[7];
            end
            dfe_pkg::ECC_SEARCH:
                shift_en = !search_stop;
            dfe_pkg::ECC_IDLE:
            begin
                shift_en = disk_bit_valid;
                din      = disk_bit;
            end
            default:
                shift_en = 1'b0;
        endcase
    end

    dfe_ecc_lfsr u_lfsr (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .load_en  (load_en),
        .load_val (load_val),
        .shift_en (shift_en && !load_en),
        .din      (din),
        .len56    (ecc_ctl_ff[`DFE_ECC_LEN56]),
        .fb_dis   (ecc_ctl_ff[`DFE_ECC_FBDIS]),
        .rev      (ecc_ctl_ff[`DFE_ECC_REV]),
        .syn_ff   (syn)
    );

    // status bytes: bit 0 carries the top syndrome bit of the byte
    for (genvar k = 0; k < 4; k++)
    begin : g_byte
        for (genvar i = 0; i < 8; i++)
        begin : g_bit
            assign syn_byte[k][i] = ecc_ctl_ff[`DFE_ECC_LEN56]
                                    ? syn[24 + 8 * k + 7 - i]
                                    : syn[8 * k + 7 - i];
        end
    end

    // ecc control: firmware write, then device self-clears
    always_comb
    begin
        nxt_ctl = ecc_ctl_ff;
        if (ctl_wr)
            nxt_ctl = reg_wdata;
        else
        begin
            if (rev_done || search_stop)
                nxt_ctl[`DFE_ECC_SHIFT] = 1'b0;
            if (ecc_clr_now)
                nxt_ctl[`DFE_ECC_CLR] = 1'b0;
        end
        if (nxt_ctl[`DFE_ECC_FRST])
            nxt_ctl = `DFE_ECC_CTL_RST;
    end

    // hardware reset sets the formatter reset bit
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            ecc_ctl_ff <= `DFE_ECC_CTL_RST;
        else
            ecc_ctl_ff <= nxt_ctl;
    end

    // ecc sequencing; a cleared shift bit also aborts a run
    always_ff @(posedge ref_clk)
    begin
        if (srst || fmt_rst || !ecc_ctl_ff[`DFE_ECC_SHIFT])
        begin
            state_ff    <= dfe_pkg::ECC_IDLE;
            bit_cnt_ff  <= 3'h0;
            byte_cnt_ff <= 9'h0;
        end
        else
        begin
            case (state_ff)
                dfe_pkg::ECC_IDLE:
                begin
                    bit_cnt_ff  <= 3'h0;
                    byte_cnt_ff <= 9'h0;
                    if (ecc_ctl_ff[`DFE_ECC_FUNC])
                        state_ff <= dfe_pkg::ECC_SEARCH;
                    else
                        state_ff <= dfe_pkg::ECC_REVERSE;
                end
                dfe_pkg::ECC_REVERSE:
                begin
                    bit_cnt_ff <= bit_cnt_ff + 3'h1;
                    if (rev_done)
                        state_ff <= dfe_pkg::ECC_IDLE;
                end
                dfe_pkg::ECC_SEARCH:
                begin
                    if (search_stop)
                        state_ff <= dfe_pkg::ECC_IDLE;
                    else
                    begin
                        bit_cnt_ff <= bit_cnt_ff + 3'h1;
                        if (bit_cnt_ff == `DFE_LAST_BIT)
                            byte_cnt_ff <= byte_cnt_ff + 9'h1;
                    end
                end
                default:
                    state_ff <= dfe_pkg::ECC_IDLE;
            endcase
        end
    end

    // correction register: byte counter or shift register
    always_ff @(posedge ref_clk)
    begin
        if (srst || fmt_rst)
            corr_ff <= 8'h0;
        else if (state_ff == dfe_pkg::ECC_REVERSE)
            corr_ff <= {corr_ff[6:0], 1'b0};
        else if (state_ff == dfe_pkg::ECC_SEARCH && !search_stop
                 && bit_cnt_ff == `DFE_LAST_BIT)
            corr_ff <= corr_ff + 8'h1;
        else if (corr_wr)
            corr_ff <= reg_wdata;
    end

    // correctable flag; finding beats the clear by function bit
    always_ff @(posedge ref_clk)
    begin
        if (srst || fmt_rst)
            corr_found_ff <= 1'b0;
        else if (search_stop && found)
            corr_found_ff <= 1'b1;
        else if (!ecc_ctl_ff[`DFE_ECC_FUNC])
            corr_found_ff <= 1'b0;
    end

    // sector length register survives a formatter reset
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            sect_ff <= 8'h0;
        else if (reg_wr && reg_addr == `DFE_ADDR_SECT)
            sect_ff <= reg_wdata;
    end

    // underflows up to register value plus one are swallowed
    assign suppress = inhibit_carry && supp_cnt_ff <= {1'b0, sect_ff};
    always_ff @(posedge ref_clk)
    begin
        if (srst || fmt_rst || !inhibit_carry)
            supp_cnt_ff <= 9'h0;
        else if (seq_underflow && suppress)
            supp_cnt_ff <= supp_cnt_ff + 9'h1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst || fmt_rst)
            underflow_pass_ff <= 1'b0;
        else
            underflow_pass_ff <= seq_underflow && !suppress;
    end

    // pins are asynchronous: two stages before the edge detect
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            idx_sync_ff <= 3'h0;
            sec_sync_ff <= 3'h0;
        end
        else
        begin
            idx_sync_ff <= {idx_sync_ff[1:0], index_pin};
            sec_sync_ff <= {sec_sync_ff[1:0], sector_pin};
        end
    end

    // sector pulses count only in hard sector mode
    always_ff @(posedge ref_clk)
    begin
        if (srst || fmt_rst)
            branch_cond_ff <= 1'b0;
        else
            branch_cond_ff <= (idx_sync_ff[1] && !idx_sync_ff[2])
                || mode_ff[`DFE_MODE_PGM_IDX]
                || (ecc_ctl_ff[`DFE_ECC_SECBR]
                    && mode_ff[`DFE_MODE_HARD_SEC]
                    && sec_sync_ff[1] && !sec_sync_ff[2]);
    end

    // formatter halt: gates dropped, disk side lines floated
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            fmt_reset_ff      <= 1'b1;
            gate_kill_ff      <= 1'b1;
            lines_drive_en_ff <= 1'b0;
        end
        else
        begin
            fmt_reset_ff      <= fmt_rst;
            gate_kill_ff      <= fmt_rst;
            lines_drive_en_ff <= !fmt_rst;
        end
    end

    // mode register; only power-on reset touches it
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            mode_ff <= 8'h0;
        else
        begin
            if (reg_wr && reg_addr == `DFE_ADDR_MODE)
                mode_ff[7:1] <= reg_wdata[7:1];
            if (host_stat_rd)
                mode_ff[`DFE_MODE_HSR] <= 1'b1;
            else if (reg_rd && reg_addr == `DFE_ADDR_MODE)
                mode_ff[`DFE_MODE_HSR] <= 1'b0;
        end
    end

    // window decode registered for the host file select
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            hrf_sel_lo_ff <= 1'b0;
            hrf_sel_hi_ff <= 1'b0;
        end
        else
        begin
            hrf_sel_lo_ff <= mode_ff[`DFE_MODE_HRF_EN]
                             && mode_ff[`DFE_MODE_HRF_SEL];
            hrf_sel_hi_ff <= mode_ff[`DFE_MODE_HRF_EN]
                             && !mode_ff[`DFE_MODE_HRF_SEL];
        end
    end

    dfe_cmd_lock u_lock (
        .ref_clk       (ref_clk),
        .srst          (srst),
        .host_cmd      (host_cmd),
        .host_auto_cmd (host_auto_cmd),
        .release_wr    (reg_wr && reg_addr == `DFE_ADDR_LOCK_REL),
        .bm_lock_ff    (bm_lock_ff),
        .xfer_lock_ff  (xfer_lock_ff),
        .pwrdn_lock_ff (pwrdn_lock_ff)
    );

    // read mux; status bytes are only meaningful while idle
    always_comb
    begin
        case (reg_addr)
            `DFE_ADDR_SECT:    rd_mux = sect_ff;
            `DFE_ADDR_ECC_CTL: rd_mux = ecc_ctl_ff;
            `DFE_ADDR_CORR:    rd_mux = corr_ff;
            `DFE_ADDR_SYN0:    rd_mux = syn_byte[0];
            `DFE_ADDR_SYN1:    rd_mux = syn_byte[1];
            `DFE_ADDR_SYN2:    rd_mux = syn_byte[2];
            `DFE_ADDR_SYN3:    rd_mux = syn_byte[3];
            `DFE_ADDR_MODE:    rd_mux = mode_ff;
            default:           rd_mux = 8'h0;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            reg_rdata_ff <= 8'h0;
            ecc_busy_ff  <= 1'b0;
        end
        else
        begin
            if (reg_rd)
                reg_rdata_ff <= rd_mux;
            ecc_busy_ff <= state_ff != dfe_pkg::ECC_IDLE;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence s_rev_last;
        rev_done && !ctl_wr;
    endsequence

    AST_CTL_HELD: assert property (
        fmt_rst && !ctl_wr |=> ecc_ctl_ff == `DFE_ECC_CTL_RST)
        else $error("ecc control not cleared under formatter reset");
    AST_REV_DONE: assert property (
        s_rev_last |=> !ecc_ctl_ff[`DFE_ECC_SHIFT]
                       && state_ff == dfe_pkg::ECC_IDLE)
        else $error("reversal did not end after eight bits");
    AST_SEARCH_CAP: assert property (
        state_ff == dfe_pkg::ECC_SEARCH |-> byte_cnt_ff <= 9'h100)
        else $error("search ran past 256 bytes");
    AST_FOUND_STOP: assert property (
        search_stop && found && !ctl_wr && !corr_wr && !fmt_rst
        |=> corr_found_ff && $stable(corr_ff)
            && !ecc_ctl_ff[`DFE_ECC_SHIFT])
        else $error("search did not stop on correctable error");
    AST_CNT_STEP: assert property (
        state_ff == dfe_pkg::ECC_SEARCH && !search_stop
        && bit_cnt_ff == `DFE_LAST_BIT && !fmt_rst
        |=> corr_ff == $past(corr_ff) + 8'h1)
        else $error("byte counter did not advance");
    AST_PRESET: assert property (
        fmt_rst |=> syn == (ecc_preset_ctrl ? 56'h0 : {56{1'b1}})
                    || !$past(fmt_rst) || $changed(ecc_preset_ctrl))
        else $error("status preset wrong under formatter reset");
    AST_FLOAT: assert property (
        fmt_rst |=> !lines_drive_en_ff && gate_kill_ff)
        else $error("lines driven during formatter reset");
    AST_UNDERFLOW: assert property (
        seq_underflow && suppress && !fmt_rst |=> !underflow_pass_ff)
        else $error("suppressed underflow leaked");
    AST_HSR: assert property (
        host_stat_rd |=> mode_ff[`DFE_MODE_HSR])
        else $error("host status read not flagged");
    AST_WINDOW: assert property (
        mode_ff[`DFE_MODE_HRF_EN] && mode_ff[`DFE_MODE_HRF_SEL]
        |=> hrf_sel_lo_ff && !hrf_sel_hi_ff)
        else $error("register file window decoded wrong");
endmodule

// ==== design/dfe_defines.svh ====
// register offsets, field positions and reset values of the ecc control
`ifndef DFE_DEFINES_SVH
`define DFE_DEFINES_SVH
`define DFE_ADDR_SECT     8'h4e
`define DFE_ADDR_ECC_CTL  8'h71
`define DFE_ADDR_CORR     8'h72
`define DFE_ADDR_SYN0     8'h73
`define DFE_ADDR_LOCK_REL 8'h73
`define DFE_ADDR_SYN1     8'h74
`define DFE_ADDR_SYN2     8'h75
`define DFE_ADDR_SYN3     8'h76
`define DFE_ADDR_MODE     8'h77
`define DFE_ECC_FUNC      0
`define DFE_ECC_SHIFT     1
`define DFE_ECC_FBDIS     2
`define DFE_ECC_CLR       3
`define DFE_ECC_SECBR     4
`define DFE_ECC_FRST      5
`define DFE_ECC_LEN56     6
`define DFE_ECC_REV       7
`define DFE_MODE_HSR      0
`define DFE_MODE_HRF_EN   1
`define DFE_MODE_HRF_SEL  2
`define DFE_MODE_PGM_IDX  5
`define DFE_MODE_HARD_SEC 7
`define DFE_ECC_CTL_RST   8'h20
`define DFE_SEARCH_BYTES  9'h100
`define DFE_LAST_BIT      3'h7
`endif

// ==== design/dfe_pkg.sv ====
// types shared by the ecc control block
package dfe_pkg;
    typedef enum logic [1:0] {
        ECC_IDLE,
        ECC_REVERSE,
        ECC_SEARCH
    } dfe_ecc_state_type;
endpackage

// ==== design/dfe_ecc_lfsr.sv ====
// 56/32-bit ecc shift register with forward and reverse feedback
`timescale 1ns/1ps
module dfe_ecc_lfsr #(
    parameter logic [55:0] FWD_POLY56 = 56'h00000000000001,
    parameter logic [31:0] FWD_POLY32 = 32'h00000001,
    parameter logic [55:0] REV_POLY56 = 56'h80000000000000,
    parameter logic [31:0] REV_POLY32 = 32'h80000000
) (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        load_en,
    input  wire logic [55:0] load_val,
    input  wire logic        shift_en,
    input  wire logic        din,
    input  wire logic        len56,
    input  wire logic        fb_dis,
    input  wire logic        rev,
    output logic      [55:0] syn_ff
);
    logic [55:0] mask;
    logic [55:0] top;
    logic [55:0] nxt_syn;
    logic        fb;

    // one bit per clock; feedback off turns it into a plain delay line
    always_comb
    begin
        mask = len56 ? {56{1'b1}} : {24'h0, 32'hffffffff};
        top  = len56 ? {1'b1, 55'h0} : {24'h0, 1'b1, 31'h0};
        if (!rev)
        begin
            fb = din ^ (len56 ? syn_ff[55] : syn_ff[31]);
            nxt_syn = {syn_ff[54:0], fb_dis & din};
            if (!fb_dis && fb)
                nxt_syn = nxt_syn ^ (len56 ? FWD_POLY56
                                           : {24'h0, FWD_POLY32});
        end
        else
        begin
            fb = din ^ syn_ff[0];
            // bits above the selected length must not leak downwards
            nxt_syn = {1'b0, syn_ff[55:1] & mask[55:1]}
                      | (fb_dis && din ? top : 56'h0);
            if (!fb_dis && fb)
                nxt_syn = nxt_syn ^ (len56 ? REV_POLY56
                                           : {24'h0, REV_POLY32});
        end
        nxt_syn = nxt_syn & mask;
    end

    // reset presets to ones; a load beats a shift
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            syn_ff <= {56{1'b1}};
        else if (load_en)
            syn_ff <= load_val;
        else if (shift_en)
            syn_ff <= nxt_syn;
    end
endmodule

// ==== design/dfe_cmd_lock.sv ====
// host command lock over buffer, transfer path and power-down bit
`timescale 1ns/1ps
module dfe_cmd_lock (
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic host_cmd,
    input  wire logic host_auto_cmd,
    input  wire logic release_wr,
    output logic      bm_lock_ff,
    output logic      xfer_lock_ff,
    output logic      pwrdn_lock_ff
);
    // a command in the same cycle as a release keeps the lock
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            bm_lock_ff    <= 1'b0;
            xfer_lock_ff  <= 1'b0;
            pwrdn_lock_ff <= 1'b0;
        end
        else if (host_cmd)
        begin
            bm_lock_ff    <= bm_lock_ff | host_auto_cmd;
            xfer_lock_ff  <= xfer_lock_ff | host_auto_cmd;
            pwrdn_lock_ff <= 1'b1;
        end
        else if (release_wr)
        begin
            bm_lock_ff    <= 1'b0;
            xfer_lock_ff  <= 1'b0;
            pwrdn_lock_ff <= 1'b0;
        end
    end

    AST_LOCK_RELEASE: assert property (@(posedge ref_clk) disable iff (srst)
        release_wr && !host_cmd |=> !bm_lock_ff && !pwrdn_lock_ff)
        else $error("lock survived a release write");
endmodule

// ==== tb/dfe_mcu_model.sv ====
// local microcontroller model on the register strobe port
`timescale 1ns/1ps
module dfe_mcu_model (
    input  wire logic       ref_clk,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata,
    output logic            rsp_v
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_wdata = 8'h00;
        rsp_v = 1'h0;
    end
    // read data is looked at one edge after the strobe edge
    always @(posedge ref_clk)
        rsp_v <= reg_rd;
    // idle bus shows the inverse, never the last value
    task automatic acc(input logic w, input logic [7:0] a, d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = ~w;
        @(posedge ref_clk);
        #1;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = ~a;
        reg_wdata = ~d;
        @(posedge ref_clk);
        #1;
    endtask
endmodule

// ==== tb/dfe_ecc_ctrl_bench.sv ====
// self-checking bench for the formatter ecc control block
`timescale 1ns/1ps
module dfe_ecc_ctrl_bench;
    logic        ref_clk = 1'h0;
    logic        srst = 1'h1;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata_ff, sd, p;
    logic        reg_wr, reg_rd, rsp_v, underflow_pass_ff, branch_cond_ff;
    logic        disk_op_active = 0, disk_bit_valid = 0, disk_bit = 0;
    logic        ecc_preset_ctrl = 0, inhibit_carry = 0, seq_underflow = 0;
    logic        index_pin = 0, sector_pin = 0, host_cmd = 0;
    logic        host_auto_cmd = 0, host_stat_rd = 0, fmt_reset_ff;
    logic        gate_kill_ff, lines_drive_en_ff, ecc_busy_ff;
    logic        corr_found_ff, bm_lock_ff, xfer_lock_ff, pwrdn_lock_ff;
    logic        hrf_sel_lo_ff, hrf_sel_hi_ff;
    logic [15:0] e;
    logic [15:0] q[$];
    int          n_errors = 0, checked = 0, cyc = 0, n;

    dfe_mcu_model mcu (.*);
    dfe_ecc_ctrl DUT (.*);

    always #12.5 ref_clk = ~ref_clk;

    task automatic chk(input string s, input logic [7:0] seen, exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s exp %h seen %h", s, exp, seen);
        end
    endtask
    task automatic cy(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    // expected value noted before the read goes out
    task automatic rc(input logic [7:0] a, exp);
        q.push_back({a, exp});
        mcu.acc(1'h0, a, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, d);
        mcu.acc(1'h1, a, d);
    endtask
    task automatic shin(input logic [7:0] v);
        for (int i = 7; i >= 0; i--)
        begin
            disk_bit_valid = 1'h1;
            disk_bit = v[i];
            cy(1);
        end
        disk_bit_valid = 1'h0;
        disk_bit = ~disk_bit;
    endtask
    task automatic br(input logic s, input logic [7:0] exp);
        index_pin = s;
        sector_pin = ~s;
        cy(3);
        index_pin = 1'h0;
        sector_pin = 1'h0;
        n = 0;
        // the branch pulse stands one cycle, already up on return
        repeat (8)
        begin
            n += branch_cond_ff;
            cy(1);
        end
        chk("branch", {7'h0, n > 0}, exp);
    endtask
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task end_of_test;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // read results taken off the queue oldest first
    always @(posedge ref_clk)
        if (rsp_v === 1'h1)
        begin
            e = q.pop_front();
            chk($sformatf("reg %h", e[15:8]), reg_rdata_ff, e[7:0]);
        end
    // hang guard, the long search needs about 2050 cycles
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            n_errors++;
            end_of_test();
        end
    end

    initial
    begin
        sd = 8'h55;
        cy(6);
        srst = 1'h0;
        chk("frst", {7'h0, fmt_reset_ff}, 8'h01);
        chk("drv", {7'h0, lines_drive_en_ff | ~gate_kill_ff}, 8'h00);
        rc(8'h71, 8'h20);
        for (logic [7:0] a = 8'h73; a != 8'h77; a++)
            rc(a, 8'hff);
        rc(8'h50, 8'h00);
        wr(8'h71, 8'hc4); // leave reset promptly
        rc(8'h71, 8'hc4);
        chk("frst", {7'h0, fmt_reset_ff}, 8'h00);
        ecc_preset_ctrl = 1'h1;
        wr(8'h71, 8'he4);
        rc(8'h71, 8'h20);
        rc(8'h76, 8'h00);
        chk("kill", {6'h0, gate_kill_ff, lines_drive_en_ff}, 8'h02);
        wr(8'h71, 8'h04); // preset still set: leaves a zero syndrome
        ecc_preset_ctrl = 1'h0;
        $display("test reset done");
        // plain shift with feedback off, status byte bit order
        sd = lfsr(sd);
        disk_op_active = 1'h1; // clear bit held off on disk ops
        shin(sd);
        rc(8'h73, {<<{sd}});
        rc(8'h74, 8'h00);
        wr(8'h71, 8'h44);
        rc(8'h73, 8'h00);
        wr(8'h71, 8'h0c);
        rc(8'h73, {<<{sd}});
        disk_op_active = 1'h0;
        cy(2);
        rc(8'h73, 8'h00);
        $display("test shift done");
        // search hits at once on a low byte error
        shin(sd);
        wr(8'h71, 8'h07);
        cy(12);
        chk("found", {7'h0, corr_found_ff}, 8'h01);
        rc(8'h71, 8'h05);
        rc(8'h72, 8'h00);
        wr(8'h71, 8'h08);
        chk("found", {7'h0, corr_found_ff}, 8'h00);
        // clean syndrome runs the full byte count
        wr(8'h71, 8'h03);
        cy(3);
        n = 0;
        while (ecc_busy_ff !== 1'h0 && n < 3000)
        begin
            cy(1);
            n++;
        end
        chk("bytes", {7'h0, n >= 2040 && n <= 2056}, 8'h01);
        rc(8'h71, 8'h01);
        rc(8'h72, 8'h00);
        // reversal feeds the correction register into the ecc
        sd = lfsr(sd);
        wr(8'h71, 8'h04);
        wr(8'h72, sd);
        wr(8'h71, 8'h06);
        cy(12);
        rc(8'h71, 8'h04);
        rc(8'h73, {<<{sd}});
        $display("test ecc done");
        for (int k = 0; k < 2; k++)
        begin
            wr(8'h4e, k[7:0]);
            inhibit_carry = 1'h1;
            p = 0;
            repeat (k + 2)
            begin
                seq_underflow = 1'h1;
                cy(1);
                seq_underflow = 1'h0;
                p = {p[6:0], underflow_pass_ff};
                cy(2);
            end
            chk("pass", p, 8'h01);
            inhibit_carry = 1'h0;
            cy(2);
        end
        for (int a = 0; a < 2; a++)
        begin
            host_auto_cmd = a[0];
            host_cmd = 1'h1;
            cy(1);
            host_cmd = 1'h0;
            cy(1);
            p = {5'h0, bm_lock_ff, xfer_lock_ff, pwrdn_lock_ff};
            chk("lock", p, {5'h0, a[0], a[0], 1'h1});
            wr(8'h73, sd);
            p = {5'h0, bm_lock_ff, xfer_lock_ff, pwrdn_lock_ff};
            chk("lock", p, 8'h00);
        end
        host_stat_rd = 1'h1;
        cy(1);
        host_stat_rd = 1'h0;
        rc(8'h77, 8'h01);
        rc(8'h77, 8'h00);
        for (logic [7:0] d = 8'h00; d != 8'h08; d += 8'h02)
        begin
            wr(8'h77, d);
            p = {6'h0, hrf_sel_hi_ff, hrf_sel_lo_ff};
            chk("hrf", p, {6'h0, d[1] & ~d[2], d[1] & d[2]});
        end
        wr(8'h77, 8'h80);
        wr(8'h71, 8'h10);
        br(1'h0, 8'h01);
        br(1'h1, 8'h01);
        wr(8'h71, 8'h00);
        br(1'h0, 8'h00);
        $display("test host done");
        cy(3);
        end_of_test();
    end
endmodule
